// [hw/promprg_ctrl.sv]
// Purpose: Programmer that drives a 32K x 8 PROM through its pins
// Assumes: Supplies switched by external regulators on our selects
// Notes:   One command at a time; accepted on START_I with READY_O
`timescale 1ns/1ps
`default_nettype none
`include "promprg_defines.svh"
module promprg_ctrl
    import promprg_pkg::*;
#(
    parameter int PULSE_CYC  = `PP_PULSE_CYC,
    parameter int MAX_PULSES = `PP_MAX_PULSES,
    parameter int SETUP_CYC  = `PP_SETUP_CYC
) (
    // Clock and reset
    input  wire logic                   CLK_I,
    input  wire logic                   RST_N_I,
    // Command port
    input  wire logic                   START_I,
    input  wire pp_cmd_t                CMD_I,
    input  wire logic [`PP_ADDR_W-1:0]  ADDR_I,
    input  wire logic [`PP_DATA_W-1:0]  WDATA_I,
    output logic                        READY_O,
    output logic                        DONE_O,
    output logic                        FAIL_O,
    output logic [`PP_DATA_W-1:0]       RDATA_O,
    output logic [`PP_ADDR_W-1:0]       FAIL_ADDR_O,
    output logic [3:0]                  PULSES_O,
    // Device pins
    output logic [`PP_ADDR_W-1:0]       ADDRESS_LINES_O,
    output logic                        ADDRESS_BIT_NINE_HV_O,
    output logic                        CHIP_EN_N_O,
    output logic                        OUT_EN_N_O,
    output logic [`PP_DATA_W-1:0]       DATA_LINES_O,
    output logic                        DATA_LINES_OE_N_O,
    input  wire logic [`PP_DATA_W-1:0]  DATA_LINES_I,
    output pp_supply_t                  SUPPLY_SEL_O
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_PULSE, ST_VSETUP, ST_VERIFY, ST_RSETUP, ST_READ
    } pp_state_t;

    pp_state_t                  state_reg;
    pp_cmd_t                    cmd_reg;
    logic [`PP_ADDR_W-1:0]      addr_reg;
    logic [`PP_DATA_W-1:0]      data_reg;
    logic [`PP_DATA_W-1:0]      rdata_reg;
    logic [3:0]                 pulses_reg;
    logic                       done_reg;
    logic                       fail_reg;
    logic [`PP_ADDR_W-1:0]      fail_addr_reg;
    logic [`PP_DATA_W-1:0]      din_s1_reg;
    logic [`PP_DATA_W-1:0]      din_s2_reg;

    // Timer shared by pulse and settle waits
    logic                       tmr_load;
    logic [15:0]                tmr_count;
    logic                       tmr_done;

    // Settle covers the two sync flops plus device access time
    localparam logic [15:0] SETUP_LD = 16'(SETUP_CYC);
    localparam logic [15:0] PULSE_LD = 16'(PULSE_CYC);
    localparam logic [3:0]  MAX_LD   = 4'(MAX_PULSES);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire start_ok   = (state_reg == ST_IDLE) && START_I;
    wire id_mode    = (cmd_reg == PP_CMD_ID_READ);
    wire verify_ok  = (din_s2_reg == data_reg);
    wire last_pulse = (pulses_reg >= MAX_LD);
    wire prog_phase = (state_reg == ST_SETUP) || (state_reg == ST_PULSE)
                      || (state_reg == ST_VSETUP) || (state_reg == ST_VERIFY);

    assign tmr_load  = start_ok
                       || (tmr_done && (state_reg == ST_SETUP))
                       || (tmr_done && (state_reg == ST_PULSE))
                       || (tmr_done && (state_reg == ST_VERIFY) && !verify_ok
                           && !last_pulse);
    assign tmr_count = (tmr_done && (state_reg == ST_SETUP)) ? PULSE_LD
                                                             : SETUP_LD;

    promprg_timer #(.W(16)) promprg_timer_inst (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .load_i  (tmr_load),
        .count_i (tmr_count),
        .done_o  (tmr_done)
    );

    // ------------------------------------------------------------
    // Data line synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            din_s1_reg <= '0;
            din_s2_reg <= '0;
        end
        else
        begin
            din_s1_reg <= DATA_LINES_I;
            din_s2_reg <= din_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            state_reg     <= ST_IDLE;
            cmd_reg       <= PP_CMD_FINAL_READ;
            addr_reg      <= '0;
            data_reg      <= `PP_ERASED_BYTE;
            rdata_reg     <= '0;
            pulses_reg    <= '0;
            done_reg      <= 1'b0;
            fail_reg      <= 1'b0;
            fail_addr_reg <= '0;
        end
        else
        begin
            done_reg <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (START_I)
                    begin
                        // Any address order is accepted per command
                        cmd_reg    <= CMD_I;
                        addr_reg   <= (CMD_I == PP_CMD_ID_READ)
                                      ? {14'h0000, ADDR_I[0]} : ADDR_I;
                        data_reg   <= WDATA_I;
                        pulses_reg <= '0;
                        fail_reg   <= 1'b0;
                        state_reg  <= (CMD_I == PP_CMD_PROGRAM) ? ST_SETUP : ST_RSETUP;
                    end
                end
                ST_SETUP:
                    if (tmr_done)
                    begin
                        pulses_reg <= pulses_reg + 4'h1;
                        state_reg  <= ST_PULSE;
                    end
                ST_PULSE:
                    if (tmr_done)
                        state_reg <= ST_VSETUP;
                ST_VSETUP:
                    state_reg <= ST_VERIFY;
                ST_VERIFY:
                    if (tmr_done)
                    begin
                        rdata_reg <= din_s2_reg;
                        if (verify_ok)
                        begin
                            done_reg  <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                        else if (last_pulse)
                        begin
                            done_reg      <= 1'b1;
                            fail_reg      <= 1'b1;
                            fail_addr_reg <= addr_reg;
                            state_reg     <= ST_IDLE;
                        end
                        else
                            state_reg <= ST_SETUP;
                    end
                ST_RSETUP:
                    if (tmr_done)
                    begin
                        rdata_reg <= din_s2_reg;
                        done_reg  <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // Address and data held from SETUP through the pulse
    assign ADDRESS_LINES_O       = addr_reg;
    assign ADDRESS_BIT_NINE_HV_O = !prog_phase && (state_reg != ST_IDLE)
                                   && id_mode;
    // Chip enable low during the pulse and the read settle (ST_RSETUP); high elsewhere inhibits
    assign CHIP_EN_N_O  = (state_reg == ST_PULSE) ? 1'b0
                        : (state_reg == ST_RSETUP) ? 1'b0
                        : 1'b1;
    assign OUT_EN_N_O   = (state_reg == ST_VERIFY) ? 1'b0
                        : (state_reg == ST_RSETUP) ? 1'b0
                        : 1'b1;
    // Only drive data while the device output is off
    assign DATA_LINES_O      = data_reg;
    assign DATA_LINES_OE_N_O = !((state_reg == ST_SETUP)
                               || (state_reg == ST_PULSE));
    assign SUPPLY_SEL_O = prog_phase ? PP_SUP_PROGRAM : PP_SUP_READ;

    // ------------------------------------------------------------
    // Command outputs
    // ------------------------------------------------------------
    // Bits can only go low; a one over a programmed zero always fails
    assign READY_O     = (state_reg == ST_IDLE);
    assign DONE_O      = done_reg;
    assign FAIL_O      = fail_reg;
    assign RDATA_O     = rdata_reg;
    assign FAIL_ADDR_O = fail_addr_reg;
    assign PULSES_O    = pulses_reg;
endmodule // promprg_ctrl
`default_nettype wire

// [hw/promprg_defines.svh]
// Purpose: Constants for the PROM programmer controller
// Assumes: 125 MHz system clock
// Notes:   Timing counts derive from the printed times
`ifndef PROMPRG_DEFINES_SVH
`define PROMPRG_DEFINES_SVH

`define PP_CLK_MHZ          125
`define PP_PULSE_US         100
`define PP_PULSE_CYC        (`PP_PULSE_US * `PP_CLK_MHZ)
`define PP_MAX_PULSES       10
`define PP_SETUP_NS         2000
`define PP_SETUP_CYC        ((`PP_SETUP_NS * `PP_CLK_MHZ + 999) / 1000)
`define PP_ADDR_W           15
`define PP_DATA_W           8
`define PP_ERASED_BYTE      8'hff
`define PP_ID_ADDR_MFG      15'h0200
`define PP_ID_ADDR_DEV      15'h0201

`endif

// [hw/promprg_pkg.sv]
// Purpose: Types for the PROM programmer controller
// Assumes: Nothing
// Notes:   Commands and supply selects
package promprg_pkg;
    typedef enum logic [1:0] {
        PP_CMD_PROGRAM,
        PP_CMD_FINAL_READ,
        PP_CMD_ID_READ
    } pp_cmd_t;

    typedef enum logic [1:0] {
        PP_SUP_READ,
        PP_SUP_PROGRAM
    } pp_supply_t;
endpackage

// [hw/promprg_timer.sv]
// Purpose: Down counter producing a one-cycle done pulse
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Load restarts the count
`timescale 1ns/1ps
`default_nettype none
module promprg_timer #(
    parameter int W = 15
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] count_i,
    output logic              done_o
);
    logic [W-1:0] cnt_reg;
    logic         run_reg;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
        end
        else if (load_i)
        begin
            cnt_reg <= count_i;
            run_reg <= 1'b1;
        end
        else if (run_reg)
        begin
            cnt_reg <= cnt_reg - 1'b1;
            if (cnt_reg == {{(W-1){1'b0}}, 1'b1})
                run_reg <= 1'b0;
        end
    end

    assign done_o = run_reg && (cnt_reg == {{(W-1){1'b0}}, 1'b1});
endmodule // promprg_timer
`default_nettype wire

// [sim/promprg_ctrl_sva.sv]
// Purpose: Pin protocol checker for the PROM programmer
// Assumes: Bound to promprg_ctrl, one clock domain
// Notes:   Pulse width counted in helper logic
`timescale 1ns/1ps
`default_nettype none
`include "promprg_defines.svh"
module promprg_ctrl_sva
    import promprg_pkg::*;
#(
    parameter int PULSE_CYC  = 20,
    parameter int MAX_PULSES = 10,
    parameter int SETUP_CYC  = 4
) (
    // Clock and command side
    input wire logic                  CLK_I,
    input wire logic                  RST_N_I,
    input wire logic                  START_I,
    input wire pp_cmd_t               CMD_I,
    input wire logic [`PP_ADDR_W-1:0] ADDR_I,
    input wire logic [`PP_DATA_W-1:0] WDATA_I,
    input wire logic                  READY_O,
    input wire logic                  DONE_O,
    input wire logic                  FAIL_O,
    input wire logic [`PP_DATA_W-1:0] RDATA_O,
    input wire logic [`PP_ADDR_W-1:0] FAIL_ADDR_O,
    input wire logic [3:0]            PULSES_O,
    // Device pins
    input wire logic [`PP_ADDR_W-1:0] ADDRESS_LINES_O,
    input wire logic                  ADDRESS_BIT_NINE_HV_O,
    input wire logic                  CHIP_EN_N_O,
    input wire logic                  OUT_EN_N_O,
    input wire logic [`PP_DATA_W-1:0] DATA_LINES_O,
    input wire logic                  DATA_LINES_OE_N_O,
    input wire pp_supply_t            SUPPLY_SEL_O
);
    int                    pulse_cnt_reg;
    logic [`PP_ADDR_W-1:0] cmd_addr_reg;
    logic [`PP_DATA_W-1:0] cmd_data_reg;
    pp_cmd_t               cmd_reg;
    wire                   prog_sup = SUPPLY_SEL_O == PP_SUP_PROGRAM;
    wire                   in_pulse = !CHIP_EN_N_O && OUT_EN_N_O && prog_sup;
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            pulse_cnt_reg <= 0;
            cmd_addr_reg  <= '0;
            cmd_data_reg  <= '0;
            cmd_reg       <= PP_CMD_PROGRAM;
        end
        else
        begin
            pulse_cnt_reg <= in_pulse ? pulse_cnt_reg + 1 : 0;
            if (START_I && READY_O)
            begin
                cmd_addr_reg <= ADDR_I;
                cmd_data_reg <= WDATA_I;
                cmd_reg      <= CMD_I;
            end
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence s_pulse_end;
        $rose(CHIP_EN_N_O) && pulse_cnt_reg != 0;
    endsequence
    sequence s_verify;
        !OUT_EN_N_O && CHIP_EN_N_O && prog_sup;
    endsequence
    a_pulse_width: assert property (s_pulse_end |-> pulse_cnt_reg == PULSE_CYC)
        else $error("program pulse width wrong");
    a_verify_follows: assert property (s_pulse_end |-> ##[1:3] s_verify)
        else $error("no verify after pulse");
    a_pass_data: assert property (DONE_O && !FAIL_O && cmd_reg == PP_CMD_PROGRAM |-> RDATA_O == cmd_data_reg)
        else $error("passed byte does not match");
    a_fail_count: assert property ($rose(FAIL_O) |-> PULSES_O == MAX_PULSES)
        else $error("failure before pulse limit");
    a_pulse_cap: assert property (PULSES_O <= MAX_PULSES)
        else $error("too many pulses");
    a_fail_addr: assert property ($rose(FAIL_O) |-> FAIL_ADDR_O == cmd_addr_reg)
        else $error("wrong failing address");
    a_prog_mode: assert property (!CHIP_EN_N_O && prog_sup |-> OUT_EN_N_O && !DATA_LINES_OE_N_O)
        else $error("bad program pin levels");
    a_data_setup: assert property ($fell(CHIP_EN_N_O) && prog_sup
        |-> $stable(DATA_LINES_O) && $stable(ADDRESS_LINES_O) && !$past(DATA_LINES_OE_N_O))
        else $error("data not set up before pulse");
    a_read_supply: assert property (!CHIP_EN_N_O && !OUT_EN_N_O |-> !prog_sup)
        else $error("read with raised supplies");
    a_id_lines: assert property (ADDRESS_BIT_NINE_HV_O |-> ADDRESS_LINES_O[14:1] == '0 && !prog_sup)
        else $error("address lines not low in id read");
    a_no_fight: assert property (!OUT_EN_N_O |-> DATA_LINES_OE_N_O)
        else $error("data line contention");
endmodule // promprg_ctrl_sva
bind promprg_ctrl promprg_ctrl_sva #(.PULSE_CYC(PULSE_CYC), .MAX_PULSES(MAX_PULSES),
    .SETUP_CYC(SETUP_CYC)) promprg_ctrl_sva_inst (.*);
`default_nettype wire

// [sim/promprg_prom_model.sv]
// Purpose: Behavioural model of the programmable memory
// Assumes: Reacts to pin levels only, no clock
// Notes:   Bits stick only after need_i pulses to one address
`timescale 1ns/1ps
`default_nettype none
module promprg_prom_model
    import promprg_pkg::*;
#(
    parameter logic [7:0] MFG_CODE = 8'h3c, // Arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h5e  // Arbitrary value
) (
    input  wire logic [14:0] addr_i,
    input  wire logic        hv_i,
    input  wire logic        ce_n_i,
    input  wire logic        oe_n_i,
    input  wire pp_supply_t  supply_i,
    input  wire logic [7:0]  dq_i,
    input  wire logic [3:0]  need_i,
    output logic [7:0]       dq_o
);
    logic [7:0]  mem [0:32767];
    logic [7:0]  last_q = 8'h00;
    logic [3:0]  hits = 4'h0;
    logic [14:0] hit_addr = 15'h7fff;
    logic [7:0]  pgm_q = 8'hff;
    wire         prog_sup = supply_i == PP_SUP_PROGRAM;
    wire         do_verify = prog_sup && !oe_n_i && ce_n_i;
    wire         do_read = !prog_sup && !ce_n_i && !oe_n_i;
    wire [7:0]   value = hv_i ? (addr_i[0] ? DEV_CODE : MFG_CODE) : mem[addr_i];
    // Released lines show the inverse of the last byte, never a stale copy
    assign dq_o = (do_verify || do_read) ? value : ~last_q;
    always @(value, do_verify, do_read)
        if (do_verify || do_read)
            last_q = value;
    initial
        foreach (mem[i])
            mem[i] = 8'hff;
    // Byte is taken as the pulse starts; the driver may let go as it ends
    always @(negedge ce_n_i)
        pgm_q = dq_i;
    // Commit at the end of a pulse; chip enable high never programs
    always @(posedge ce_n_i)
        if (prog_sup && oe_n_i)
        begin
            hits = (addr_i == hit_addr) ? hits + 4'h1 : 4'h1;
            hit_addr = addr_i;
            if (hits >= need_i)
                mem[addr_i] = mem[addr_i] & pgm_q;
        end
endmodule // promprg_prom_model
`default_nettype wire

// [sim/prom_program_verify_signature_test.sv]
// Purpose: Self-checking bench for the PROM programmer
// Assumes: Short pulse and setup counts
// Notes:   Model codes are arbitrary values
`timescale 1ns/1ps
`default_nettype none
module prom_program_verify_signature_test;
    import promprg_pkg::*;
    localparam logic [7:0] MFG = 8'h3c;
    localparam logic [7:0] DEV = 8'h5e;
    logic clk = 0, rst_n = 0, start = 0, ready, done, fail, hv, ce_n, oe_n, dq_oe_n;
    pp_cmd_t cmd = PP_CMD_PROGRAM;
    pp_supply_t supply;
    logic [14:0] addr = '0, fail_addr, addr_pins;
    logic [7:0] wdata = '0, rdata, dq_out, mdl_dq;
    logic [3:0] pulses, need = 4'h1;
    int bad_count = 0, checked = 0;
    wire [7:0] dq_wire = dq_oe_n ? mdl_dq : dq_out;
    promprg_ctrl #(.PULSE_CYC(20), .MAX_PULSES(10), .SETUP_CYC(4)) promprg_ctrl_inst (
        .CLK_I(clk), .RST_N_I(rst_n), .START_I(start), .CMD_I(cmd), .ADDR_I(addr),
        .WDATA_I(wdata), .READY_O(ready), .DONE_O(done), .FAIL_O(fail), .RDATA_O(rdata),
        .FAIL_ADDR_O(fail_addr), .PULSES_O(pulses), .ADDRESS_LINES_O(addr_pins),
        .ADDRESS_BIT_NINE_HV_O(hv), .CHIP_EN_N_O(ce_n), .OUT_EN_N_O(oe_n),
        .DATA_LINES_O(dq_out), .DATA_LINES_OE_N_O(dq_oe_n), .DATA_LINES_I(dq_wire),
        .SUPPLY_SEL_O(supply));
    promprg_prom_model #(.MFG_CODE(MFG), .DEV_CODE(DEV)) promprg_prom_model_inst (
        .addr_i(addr_pins), .hv_i(hv), .ce_n_i(ce_n), .oe_n_i(oe_n), .supply_i(supply),
        .dq_i(dq_wire), .need_i(need), .dq_o(mdl_dq));
    task automatic chk(input bit ok, input string msg);
        checked++;
        if (!ok)
        begin
            bad_count++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic run_cmd(input pp_cmd_t c, input logic [14:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        start <= 1'b1;
        cmd <= c;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        start <= 1'b0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 1000);
        chk(n < 1000, "command never finished");
    endtask
    task automatic tally_and_finish();
        if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_program(input logic [3:0] nd, input logic [14:0] a, input logic [7:0] d);
        need <= nd;
        run_cmd(PP_CMD_PROGRAM, a, d);
        chk(fail === 1'b0 && pulses === nd && rdata === d, "program result");
    endtask
    task automatic t_program_fail();
        need <= 4'h1;
        run_cmd(PP_CMD_PROGRAM, 15'h0010, 8'hf0);
        chk(fail === 1'b1 && pulses === 4'ha, "failure after ten pulses");
        chk(fail_addr === 15'h0010, "failing address");
    endtask
    task automatic t_read(input pp_cmd_t c, input logic [14:0] a, input logic [7:0] exp);
        run_cmd(c, a, 8'h00);
        chk(rdata === exp && fail === 1'b0, "read data");
    endtask
    //------------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------------
    initial
    begin
        forever #4 clk = ~clk;
    end
    initial
    begin
        repeat (3) @(posedge clk);
        chk(ready === 1'b1 && ce_n === 1'b1 && dq_oe_n === 1'b1, "reset levels");
        rst_n <= 1'b1;
        t_program(4'h1, 15'h0010, 8'h0f);
        t_program(4'h3, 15'h7ffe, 8'ha5);
        t_program_fail();
        t_read(PP_CMD_FINAL_READ, 15'h0010, 8'h00);
        t_read(PP_CMD_FINAL_READ, 15'h7ffe, 8'ha5);
        t_read(PP_CMD_FINAL_READ, 15'h0123, 8'hff);
        t_read(PP_CMD_ID_READ, 15'h0000, MFG);
        t_read(PP_CMD_ID_READ, 15'h0001, DEV);
        t_read(PP_CMD_ID_READ, 15'h7ffe, MFG);
        tally_and_finish();
    end
    // Longest run is about 440 cycles of traffic
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end
endmodule // prom_program_verify_signature_test
`default_nettype wire
